// ### core/mtd_pkg.sv
package mtd_pkg;

  // presence-detect byte indices handled by this block
  localparam logic [7:0] IDX_GENERAL_ATTR = 8'h16;
  localparam logic [7:0] IDX_TCK_SECOND = 8'h17;
  localparam logic [7:0] IDX_TAC_SECOND = 8'h18;
  localparam logic [7:0] IDX_TCK_THIRD = 8'h19;
  localparam logic [7:0] IDX_TAC_THIRD = 8'h1A;
  localparam logic [7:0] IDX_TRP_MIN = 8'h1B;
  localparam logic [7:0] IDX_TRRD_MIN = 8'h1C;
  localparam logic [7:0] IDX_TRCD_MIN = 8'h1D;
  localparam logic [7:0] IDX_TRAS_MIN = 8'h1E;
  localparam logic [7:0] IDX_ROW_DENSITY = 8'h1F;
  localparam int NUM_BYTES = 10;
  localparam int NUM_TIMES = 8;
  localparam int NUM_INVALID = 9;

  // apb byte addresses of block-owned registers (raw bytes sit at index * 4)
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_TIME_BASE = 8'h08;
  localparam logic [7:0] ADDR_MISC = 8'h28;

  // control register fields
  localparam int CTRL_ROLLUP_BIT = 0;
  localparam int CTRL_CLEAR_BIT = 1;
  localparam logic CTRL_ROLLUP_RESET = 1'b1;

  // status register fields
  localparam int STAT_LOADED_LSB = 0;
  localparam int STAT_ALL_LOADED_BIT = 15;
  localparam int STAT_INVALID_LSB = 16;

  // misc register fields
  localparam int MISC_FEAT_LSB = 0;
  localparam int MISC_LOW_TOL_BIT = 4;
  localparam int MISC_HIGH_TOL_BIT = 5;
  localparam int MISC_DENSITY_LSB = 8;

  // general attribute byte fields
  localparam int GEN_LOW_TOL_BIT = 4;
  localparam int GEN_HIGH_TOL_BIT = 5;
  localparam logic [7:0] GEN_RESERVED_MASK = 8'h3F;

  // fixed-point scaling, unit is one hundredth of a nanosecond
  localparam logic [15:0] HUNDREDTHS_PER_NS = 16'h0064;
  localparam logic [15:0] HUNDREDTHS_PER_TENTH = 16'h000A;
  localparam logic [15:0] HUNDREDTHS_PER_QUARTER = 16'h0019;
  localparam logic [4:0] ROLLUP_ADD_NS = 5'h0F;
  localparam logic [3:0] ROLLUP_MAX_NIBBLE = 4'h3;
  localparam logic [3:0] TENTHS_MAX = 4'h9;

endpackage : mtd_pkg

// ### core/mtd_decoder.sv
`timescale 1ns/1ps
module mtd_decoder
  import mtd_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_spd_valid,
  input wire logic [7:0] i_spd_index,
  input wire logic [7:0] i_spd_byte,
  output logic [3:0] o_feature_flags,
  output logic o_high_tol_5pct,
  output logic o_low_tol_5pct,
  output logic [15:0] o_tck_second,
  output logic [15:0] o_tac_second,
  output logic [15:0] o_tck_third,
  output logic [15:0] o_tac_third,
  output logic [15:0] o_trp_min,
  output logic [15:0] o_trrd_min,
  output logic [15:0] o_trcd_min,
  output logic [15:0] o_tras_min,
  output logic [7:0] o_row_sizes,
  output logic [NUM_INVALID-1:0] o_invalid,
  output logic o_all_loaded
);

  typedef struct packed {
    logic [NUM_BYTES-1:0][7:0] raw;
    logic [NUM_BYTES-1:0] loaded;
    logic rollup;
    logic [NUM_TIMES-1:0][15:0] times;
    logic [NUM_INVALID-1:0] invalid;
    logic all_loaded;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } mtd_state_t;

  mtd_state_t s;
  mtd_state_t next_s;

  // tenths-granular byte to hundredths, with optional 16..18 ns roll-up
  function automatic logic [15:0] dec_tenths(input logic [7:0] b, input logic rollup);
    logic [4:0] whole;
    whole = {1'b0, b[7:4]};
    if (rollup && b[7:4] != 4'h0 && b[7:4] <= ROLLUP_MAX_NIBBLE) begin
      whole = whole + ROLLUP_ADD_NS;
    end
    return 16'(whole) * HUNDREDTHS_PER_NS + 16'(b[3:0]) * HUNDREDTHS_PER_TENTH;
  endfunction : dec_tenths

  // quarter-granular byte to hundredths
  function automatic logic [15:0] dec_quarter(input logic [7:0] b);
    return 16'(b[7:2]) * HUNDREDTHS_PER_NS + 16'(b[1:0]) * HUNDREDTHS_PER_QUARTER;
  endfunction : dec_quarter

  // whole-nanosecond byte to hundredths
  function automatic logic [15:0] dec_whole(input logic [7:0] b);
    return 16'(b) * HUNDREDTHS_PER_NS;
  endfunction : dec_whole

  // tenths-field validity: integer nonzero and tenths in range
  function automatic logic bad_tenths(input logic [7:0] b);
    return (b[7:4] == 4'h0) || (b[3:0] > TENTHS_MAX);
  endfunction : bad_tenths

  // raw byte slot index to byte address
  function automatic logic [7:0] raw_addr(input int i);
    return 8'((int'(IDX_GENERAL_ATTR) + i) * 4);
  endfunction : raw_addr

  logic wr_done;
  logic clear_req;
  logic [31:0] rd_word;
  logic rd_hit;

  // apb read decode of the current address
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit = 1'b0;
    if (i_paddr == ADDR_CTRL) begin
      rd_hit = 1'b1;
      rd_word[CTRL_ROLLUP_BIT] = s.rollup;
    end else if (i_paddr == ADDR_STATUS) begin
      rd_hit = 1'b1;
      rd_word[STAT_LOADED_LSB +: NUM_BYTES] = s.loaded;
      rd_word[STAT_ALL_LOADED_BIT] = s.all_loaded;
      rd_word[STAT_INVALID_LSB +: NUM_INVALID] = s.invalid;
    end else if (i_paddr == ADDR_MISC) begin
      rd_hit = 1'b1;
      rd_word[MISC_FEAT_LSB +: 4] = s.raw[0][3:0];
      rd_word[MISC_LOW_TOL_BIT] = s.raw[0][GEN_LOW_TOL_BIT];
      rd_word[MISC_HIGH_TOL_BIT] = s.raw[0][GEN_HIGH_TOL_BIT];
      rd_word[MISC_DENSITY_LSB +: 8] = s.raw[9];
    end
    for (int t = 0; t < NUM_TIMES; t++) begin
      if (i_paddr == 8'(int'(ADDR_TIME_BASE) + t * 4)) begin
        rd_hit = 1'b1;
        rd_word = {16'h0000, s.times[t]};
      end
    end
    for (int i = 0; i < NUM_BYTES; i++) begin
      if (i_paddr == raw_addr(i)) begin
        rd_hit = 1'b1;
        rd_word = {24'h000000, s.raw[i]};
      end
    end
  end

  // write completes only at the access edge with pready high
  assign wr_done = i_psel && i_penable && s.pready && i_pwrite && !s.pslverr;
  assign clear_req = wr_done && i_pwdata[CTRL_CLEAR_BIT];

  // next-state for bus, byte capture and decoding
  always_comb begin
    next_s = s;
    next_s.pready = 1'b0;
    next_s.pslverr = 1'b0;
    // setup phase: answer in the first access cycle
    if (i_psel && !i_penable) begin
      next_s.pready = 1'b1;
      next_s.prdata = i_pwrite ? 32'h0000_0000 : rd_word;
      next_s.pslverr = !rd_hit || (i_pwrite && i_paddr != ADDR_CTRL);
    end
    if (wr_done) begin
      next_s.rollup = i_pwdata[CTRL_ROLLUP_BIT];
    end
    // byte capture; a new byte beats a clear in the same cycle
    for (int i = 0; i < NUM_BYTES; i++) begin
      if (i_spd_valid && i_spd_index == 8'(int'(IDX_GENERAL_ATTR) + i)) begin
        next_s.raw[i] = (i == 0) ? (i_spd_byte & GEN_RESERVED_MASK) : i_spd_byte;
        next_s.loaded[i] = 1'b1;
      end else if (clear_req) begin
        next_s.loaded[i] = 1'b0;
      end
    end
    next_s.all_loaded = &s.loaded;
    // decoded times from the stored bytes
    next_s.times[0] = dec_tenths(s.raw[1], s.rollup);
    next_s.times[1] = dec_tenths(s.raw[2], s.rollup);
    next_s.times[2] = dec_quarter(s.raw[3]);
    next_s.times[3] = dec_quarter(s.raw[4]);
    for (int t = 4; t < NUM_TIMES; t++) begin
      next_s.times[t] = dec_whole(s.raw[t + 1]);
    end
    // validity of loaded fields
    next_s.invalid[0] = s.loaded[1] && bad_tenths(s.raw[1]);
    next_s.invalid[1] = s.loaded[2] && bad_tenths(s.raw[2]);
    next_s.invalid[2] = s.loaded[3] && (s.raw[3][7:2] == 6'h00);
    next_s.invalid[3] = s.loaded[4] && (s.raw[4][7:2] == 6'h00);
    for (int t = 4; t < NUM_TIMES; t++) begin
      next_s.invalid[t] = s.loaded[t + 1] && (s.raw[t + 1] == 8'h00);
    end
    next_s.invalid[8] = s.loaded[9] && (s.raw[9] == 8'h00);
  end

  // single state register
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      s <= '0;
      s.rollup <= CTRL_ROLLUP_RESET;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from state
  assign o_prdata = s.prdata;
  assign o_pready = s.pready;
  assign o_pslverr = s.pslverr;
  assign o_feature_flags = s.raw[0][3:0];
  assign o_high_tol_5pct = s.raw[0][GEN_HIGH_TOL_BIT];
  assign o_low_tol_5pct = s.raw[0][GEN_LOW_TOL_BIT];
  assign o_tck_second = s.times[0];
  assign o_tac_second = s.times[1];
  assign o_tck_third = s.times[2];
  assign o_tac_third = s.times[3];
  assign o_trp_min = s.times[4];
  assign o_trrd_min = s.times[5];
  assign o_trcd_min = s.times[6];
  assign o_tras_min = s.times[7];
  assign o_row_sizes = s.raw[9];
  assign o_invalid = s.invalid;
  assign o_all_loaded = s.all_loaded;

  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);

  // capture check helpers
  logic cap_gen;
  logic cap_tck2;
  logic cap_density;
  assign cap_gen = i_spd_valid && i_spd_index == IDX_GENERAL_ATTR;
  assign cap_tck2 = i_spd_valid && i_spd_index == IDX_TCK_SECOND;
  assign cap_density = i_spd_valid && i_spd_index == IDX_ROW_DENSITY;

  // feature flags follow the captured byte, reserved bits 7:6 stored as zero
  gen_flags_a: assert property (cap_gen |=> (o_feature_flags == $past(i_spd_byte[3:0]) && s.raw[0][7:6] == 2'b00))
    else $error("general flags not captured");

  // tolerance bits land on their outputs
  tol_bits_a: assert property (cap_gen |=> (o_high_tol_5pct == $past(i_spd_byte[5]) && o_low_tol_5pct == $past(i_spd_byte[4])))
    else $error("tolerance bits misplaced");

  // high nibble of one with rollup gives 16 ns plus tenths
  rollup_value_a: assert property ((cap_tck2 && i_spd_byte[7:4] == 4'h1 && s.rollup && i_spd_byte[3:0] <= 4'h9)
      ##1 (!cap_tck2 && s.rollup) |=> (o_tck_second == 16'h0640 + 16'($past(i_spd_byte[3:0], 2)) * 16'h000A))
    else $error("roll-up decode wrong");

  // plain tenths decode for nibble above three
  tenths_value_a: assert property ((cap_tck2 && i_spd_byte[7:4] > 4'h3) ##1 !cap_tck2
      |=> (o_tck_second == 16'($past(i_spd_byte[7:4], 2)) * 16'h0064 + 16'($past(i_spd_byte[3:0], 2)) * 16'h000A))
    else $error("tenths decode wrong");

  // quarter fields only yield multiples of 25
  quarter_grid_a: assert property ((o_tck_third % 16'h0019 == 16'h0000) && (o_tac_third % 16'h0019 == 16'h0000))
    else $error("quarter grid broken");

  // whole-ns fields only yield multiples of 100 up to 255 ns
  whole_grid_a: assert property ((o_trp_min % 16'h0064 == 16'h0000) && (o_tras_min <= 16'h639C))
    else $error("whole ns grid broken");

  // quarter decode of the third-latency cycle time
  quarter_value_a: assert property ((i_spd_valid && i_spd_index == IDX_TCK_THIRD)
      ##1 !(i_spd_valid && i_spd_index == IDX_TCK_THIRD)
      |=> (o_tck_third == 16'($past(i_spd_byte[7:2], 2)) * 16'h0064 + 16'($past(i_spd_byte[1:0], 2)) * 16'h0019))
    else $error("quarter decode wrong");

  // activate-to-activate whole nanoseconds
  trrd_value_a: assert property ((i_spd_valid && i_spd_index == IDX_TRRD_MIN)
      ##1 !(i_spd_valid && i_spd_index == IDX_TRRD_MIN)
      |=> (o_trrd_min == 16'($past(i_spd_byte, 2)) * 16'h0064))
    else $error("trrd decode wrong");

  // row-to-column whole nanoseconds
  trcd_value_a: assert property ((i_spd_valid && i_spd_index == IDX_TRCD_MIN)
      ##1 !(i_spd_valid && i_spd_index == IDX_TRCD_MIN)
      |=> (o_trcd_min == 16'($past(i_spd_byte, 2)) * 16'h0064))
    else $error("trcd decode wrong");

  // density bitmap copied as offered
  density_copy_a: assert property (cap_density |=> (o_row_sizes == $past(i_spd_byte)))
    else $error("density bitmap not copied");

  // zero third-latency integer field flagged
  quarter_zero_a: assert property ((i_spd_valid && i_spd_index == IDX_TAC_THIRD && i_spd_byte[7:2] == 6'h00)
      ##1 !(i_spd_valid && i_spd_index == IDX_TAC_THIRD) |=> o_invalid[3])
    else $error("zero quarter field not flagged");

  // refused write (any address but control) reports an error with the answer
  apb_refuse_a: assert property ((i_psel && !i_penable && i_pwrite && i_paddr != ADDR_CTRL)
      |=> (o_pready && o_pslverr))
    else $error("refused write not reported");

  // zero density byte flagged two cycles after capture
  density_zero_a: assert property ((cap_density && i_spd_byte == 8'h00) ##1 !cap_density |=> o_invalid[8])
    else $error("zero density not flagged");

  // multi-bit density accepted without flag
  density_multi_a: assert property ((cap_density && i_spd_byte == 8'h0C) ##1 !cap_density |=> (!o_invalid[8] && o_row_sizes == 8'h0C))
    else $error("multi-bit density rejected");

  // tenths nibble above nine flags the access time
  tenths_range_a: assert property ((i_spd_valid && i_spd_index == IDX_TAC_SECOND && i_spd_byte[3:0] > 4'h9)
      ##1 !(i_spd_valid && i_spd_index == IDX_TAC_SECOND) |=> o_invalid[1])
    else $error("tenths range not flagged");

  // apb answers in the first access cycle
  apb_ready_a: assert property ((i_psel && !i_penable) |=> o_pready ##1 !o_pready)
    else $error("apb answer timing wrong");

endmodule : mtd_decoder

// ### dv/mtd_spd_model.sv
`timescale 1ns/1ps
// presence-detect memory side: offers one byte per request
module mtd_spd_model (
  input wire logic i_clk,
  output logic o_valid,
  output logic [7:0] o_index,
  output logic [7:0] o_byte
);
  // idle lines until the first byte is offered
  initial begin
    o_valid = 1'b0;
    o_index = 8'h00;
    o_byte = 8'h00;
  end

  // one-cycle offer, then released lines show the inverse of the last value
  task automatic send(input logic [7:0] idx, input logic [7:0] val);
    @(posedge i_clk);
    o_valid <= 1'b1;
    o_index <= idx;
    o_byte <= val;
    @(posedge i_clk);
    o_valid <= 1'b0;
    o_index <= ~idx;
    o_byte <= ~val;
  endtask : send
endmodule : mtd_spd_model

// ### dv/module_timing_field_decoder_tb.sv
`timescale 1ns/1ps
module module_timing_field_decoder_tb;
  import mtd_pkg::*;
  typedef struct packed {logic [7:0] idx; logic [7:0] val; logic [15:0] exp; logic vchk; logic inv;} mtd_row_t;
  logic i_sys_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
  logic [7:0] i_paddr = 8'h00;
  logic [31:0] i_pwdata = 32'h0000_0000, rd;
  logic er;
  logic [31:0] o_prdata;
  logic o_pready, o_pslverr, sv, o_high_tol_5pct, o_low_tol_5pct, o_all_loaded;
  logic [7:0] si, sb, o_row_sizes;
  logic [3:0] o_feature_flags;
  logic [15:0] o_tck_second, o_tac_second, o_tck_third, o_tac_third, o_trp_min, o_trrd_min, o_trcd_min, o_tras_min;
  logic [NUM_INVALID-1:0] o_invalid;
  int err_total = 0, cmp_count = 0, cyc = 0;
  // ordinary cases: index, byte, decoded value, value checked, invalid flag
  mtd_row_t rows [20] = '{
    '{8'h17, 8'h3A, 16'h0000, 1'b0, 1'b1}, '{8'h17, 8'h99, 16'h03DE, 1'b1, 1'b0},
    '{8'h17, 8'h30, 16'h0708, 1'b1, 1'b0}, '{8'h17, 8'h15, 16'h0672, 1'b1, 1'b0},
    '{8'h18, 8'h09, 16'h0000, 1'b0, 1'b1}, '{8'h18, 8'h2B, 16'h0000, 1'b0, 1'b1},
    '{8'h18, 8'h29, 16'h06FE, 1'b1, 1'b0},
    '{8'h19, 8'h01, 16'h0000, 1'b0, 1'b1}, '{8'h19, 8'hFF, 16'h18E7, 1'b1, 1'b0},
    '{8'h1A, 8'h02, 16'h0000, 1'b0, 1'b1}, '{8'h1A, 8'h05, 16'h007D, 1'b1, 1'b0},
    '{8'h1B, 8'h00, 16'h0000, 1'b0, 1'b1}, '{8'h1B, 8'hFF, 16'h639C, 1'b1, 1'b0},
    '{8'h1C, 8'h01, 16'h0064, 1'b1, 1'b0}, '{8'h1D, 8'h1E, 16'h0BB8, 1'b1, 1'b0},
    '{8'h1E, 8'h3C, 16'h1770, 1'b1, 1'b0}, '{8'h1F, 8'h00, 16'h0000, 1'b1, 1'b1},
    '{8'h1F, 8'h0C, 16'h000C, 1'b1, 1'b0}, '{8'h16, 8'h25, 16'h0025, 1'b1, 1'b0},
    '{8'h16, 8'hFF, 16'h003F, 1'b1, 1'b0}};

  mtd_spd_model spd (.i_clk(i_sys_clk), .o_valid(sv), .o_index(si), .o_byte(sb));
  mtd_decoder dut (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
    .o_pslverr(o_pslverr), .i_spd_valid(sv), .i_spd_index(si), .i_spd_byte(sb), .o_feature_flags(o_feature_flags),
    .o_high_tol_5pct(o_high_tol_5pct), .o_low_tol_5pct(o_low_tol_5pct), .o_tck_second(o_tck_second),
    .o_tac_second(o_tac_second), .o_tck_third(o_tck_third), .o_tac_third(o_tac_third), .o_trp_min(o_trp_min),
    .o_trrd_min(o_trrd_min), .o_trcd_min(o_trcd_min), .o_tras_min(o_tras_min), .o_row_sizes(o_row_sizes),
    .o_invalid(o_invalid), .o_all_loaded(o_all_loaded));

  // 10 MHz clock
  always #50 i_sys_clk = ~i_sys_clk;

  // hang guard
  always @(posedge i_sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_total++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    if (err_total == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
      err_total++;
    end
  endtask : chk

  // one apb transfer, request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
    @(posedge i_sys_clk);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= wr;
    i_paddr <= addr;
    i_pwdata <= wd;
    @(posedge i_sys_clk);
    i_penable <= 1'b1;
    do @(posedge i_sys_clk); while (o_pready !== 1'b1);
    rd = o_prdata;
    er = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask : apb

  function automatic logic [15:0] dec_out(input logic [7:0] idx);
    case (idx)
      IDX_GENERAL_ATTR: return {10'h000, o_high_tol_5pct, o_low_tol_5pct, o_feature_flags};
      IDX_TCK_SECOND: return o_tck_second;
      IDX_TAC_SECOND: return o_tac_second;
      IDX_TCK_THIRD: return o_tck_third;
      IDX_TAC_THIRD: return o_tac_third;
      IDX_TRP_MIN: return o_trp_min;
      IDX_TRRD_MIN: return o_trrd_min;
      IDX_TRCD_MIN: return o_trcd_min;
      IDX_TRAS_MIN: return o_tras_min;
      default: return {8'h00, o_row_sizes};
    endcase
  endfunction : dec_out

  // main sequence
  initial begin
    repeat (3) @(posedge i_sys_clk);
    i_rstn <= 1'b1;
    for (int k = 0; k < 20; k++) begin
      spd.send(rows[k].idx, rows[k].val);
      repeat (2) @(posedge i_sys_clk);
      if (rows[k].vchk) chk("decoded", 32'(rows[k].exp), 32'(dec_out(rows[k].idx)));
      if (rows[k].idx != IDX_GENERAL_ATTR) chk("invalid", 32'(rows[k].inv), 32'(o_invalid[rows[k].idx - 8'h17]));
    end
    chk("all_loaded", 32'h1, 32'(o_all_loaded));
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("status", 32'h0000_83FF, rd);
    apb(1'b0, 8'h58, 32'h0);
    chk("raw_general", 32'h0000_003F, rd);
    apb(1'b0, ADDR_MISC, 32'h0);
    chk("misc", 32'h0000_0C3F, rd);
    apb(1'b0, ADDR_TIME_BASE, 32'h0);
    chk("tck2_reg", 32'h0000_0672, rd);
    apb(1'b0, 8'h24, 32'h0);
    chk("tras_reg", 32'h0000_1770, rd);
    // roll-up switched off: nibble 1 is a plain nanosecond
    apb(1'b1, ADDR_CTRL, 32'h0);
    spd.send(IDX_TCK_SECOND, 8'h15);
    repeat (2) @(posedge i_sys_clk);
    chk("tck2_plain", 32'h0000_0096, 32'(o_tck_second));
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk("ctrl", 32'h0, rd);
    apb(1'b1, ADDR_CTRL, 32'h1);
    // refused accesses
    apb(1'b0, 8'h80, 32'h0);
    chk("unmapped_data", 32'h0000_0000, rd);
    chk("unmapped_err", 32'h0000_0001, 32'(er));
    apb(1'b1, ADDR_STATUS, 32'hFFFF_FFFF);
    chk("ro_write_err", 32'h1, 32'(er));
    // clear loaded, then an ignored index
    apb(1'b1, ADDR_CTRL, 32'h3);
    spd.send(8'h20, 8'h55);
    repeat (2) @(posedge i_sys_clk);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("status_clr", 32'h0, rd);
    chk("all_loaded_clr", 32'h0, 32'(o_all_loaded));
    // reset in mid-run
    spd.send(IDX_TRRD_MIN, 8'h2D);
    i_rstn <= 1'b0;
    repeat (3) @(posedge i_sys_clk);
    i_rstn <= 1'b1;
    chk("trrd_rst", 32'h0, 32'(o_trrd_min));
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk("ctrl_rst", 32'h1, rd);
    print_verdict();
  end
endmodule : module_timing_field_decoder_tb
